// *** include/psw_pkg.sv ***
package alu_pkg;

   // Bit positions inside the status byte
   localparam int CARRY_BIT    = 7;
   localparam int AUX_BIT      = 6;
   localparam int USER_A_BIT   = 5;
   localparam int BANK_HI_BIT  = 4;
   localparam int BANK_LO_BIT  = 3;
   localparam int OVERFLOW_BIT = 2;
   localparam int USER_B_BIT   = 1;
   localparam int PARITY_BIT   = 0;
   localparam int NIBBLE_TOP   = 3;
   localparam int BYTE_TOP     = 7;

   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [1:0] BANK_RESET      = 2'h0;
   localparam logic [7:0] MUL_BYTE_MAX_HI = 8'h00;
   localparam logic [7:0] ZERO_BYTE       = 8'h00;
   localparam logic [1:0] POINTER_PAD     = 2'h0;

   // Register bus map
   localparam logic [7:0]  STATUS_OFFSET = 8'h00;
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
   localparam logic [23:0] READ_PAD      = 24'h00_0000;

   // Operation reported by the execution unit for the current cycle
   typedef enum logic [2:0] {
      alu_none,
      alu_add,
      alu_addc,
      alu_subb,
      alu_mul,
      alu_div,
      alu_other_arith
   } alu_op_type;

   typedef struct packed {
      alu_op_type op;
      logic [7:0] operand_a;
      logic [7:0] operand_b;
   } alu_request_type;

   // Register-file addresses derived from the bank select
   typedef struct packed {
      logic [4:0] reg_address;
      logic [4:0] pointer_address;
   } bank_address_type;

endpackage

// *** hdl/program_status_flags.sv ***
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module program_status_flags (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire alu_pkg::alu_request_type  alu_req_i,
   input  wire logic [7:0]                accumulator_i,
   input  wire logic [2:0]                reg_index_i,
   input  wire logic                      pointer_sel_i,
   output alu_pkg::bank_address_type      bank_addr_o,
   output logic [7:0]                     program_status_word_o
);
   import alu_pkg::*;

   logic       carry_flag;
   logic       aux_carry_flag;
   logic       user_flag_a;
   logic       user_flag_b;
   logic [1:0] reg_bank_select;
   logic       overflow_flag;
   logic       parity;

   logic       bus_take;
   logic       status_hit;
   logic       status_write;
   logic [7:0] write_byte;

   logic       carry_in;
   logic [8:0] sum_wide;
   logic [4:0] sum_nibble;
   logic [8:0] diff_wide;
   logic [4:0] diff_nibble;
   logic [15:0] product;
   logic       is_arith;
   logic       next_carry;
   logic       next_aux;
   logic       next_overflow;
   logic       ov_group;

   // Bus request decode; one transfer per strobe, ack blocks a second take
   // Only the low byte lane carries the status word; upper lanes are never looked at
   assign bus_take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign status_hit   = (wb_adr_i == STATUS_OFFSET);
   assign status_write = bus_take && wb_we_i && status_hit && wb_sel_i[0];
   assign write_byte   = wb_dat_i[BYTE_TOP:0];

   // Arithmetic results; carry-in only counts for the carry-using forms
   assign carry_in    = ((alu_req_i.op == alu_addc) || (alu_req_i.op == alu_subb)) && carry_flag;
   assign sum_wide    = {1'b0, alu_req_i.operand_a} + {1'b0, alu_req_i.operand_b}
                        + {8'h00, carry_in};
   assign sum_nibble  = {1'b0, alu_req_i.operand_a[NIBBLE_TOP:0]}
                        + {1'b0, alu_req_i.operand_b[NIBBLE_TOP:0]} + {4'h0, carry_in};
   assign diff_wide   = {1'b0, alu_req_i.operand_a} - {1'b0, alu_req_i.operand_b}
                        - {8'h00, carry_in};
   assign diff_nibble = {1'b0, alu_req_i.operand_a[NIBBLE_TOP:0]}
                        - {1'b0, alu_req_i.operand_b[NIBBLE_TOP:0]} - {4'h0, carry_in};
   assign product     = alu_req_i.operand_a * alu_req_i.operand_b;
   assign is_arith    = (alu_req_i.op != alu_none);
   assign ov_group    = is_arith && (alu_req_i.op != alu_other_arith);

   // Flag values produced by the current operation
   always_comb begin
      next_carry    = 1'b0;
      next_aux      = 1'b0;
      next_overflow = overflow_flag;
      case (alu_req_i.op)
         alu_add, alu_addc: begin
            next_carry    = sum_wide[BYTE_TOP + 1];
            next_aux      = sum_nibble[NIBBLE_TOP + 1];
            next_overflow = (alu_req_i.operand_a[BYTE_TOP] == alu_req_i.operand_b[BYTE_TOP])
                            && (sum_wide[BYTE_TOP] != alu_req_i.operand_a[BYTE_TOP]);
         end
         alu_subb: begin
            next_carry    = diff_wide[BYTE_TOP + 1];
            next_aux      = diff_nibble[NIBBLE_TOP + 1];
            next_overflow = (alu_req_i.operand_a[BYTE_TOP] != alu_req_i.operand_b[BYTE_TOP])
                            && (diff_wide[BYTE_TOP] != alu_req_i.operand_a[BYTE_TOP]);
         end
         alu_mul: begin
            next_overflow = (product[15:8] != MUL_BYTE_MAX_HI);
         end
         alu_div: begin
            next_overflow = (alu_req_i.operand_b == ZERO_BYTE);
         end
         default: begin
            next_overflow = overflow_flag;
         end
      endcase
   end

   // Carry pair; the execution unit wins over a bus write in the same cycle
   // Software loses such a collision silently, so firmware must not race the ALU
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry_flag     <= STATUS_RESET[CARRY_BIT];
         aux_carry_flag <= STATUS_RESET[AUX_BIT];
      end else if (is_arith) begin
         carry_flag     <= next_carry;
         aux_carry_flag <= next_aux;
      end else if (status_write) begin
         carry_flag     <= write_byte[CARRY_BIT];
         aux_carry_flag <= write_byte[AUX_BIT];
      end
   end

   // Software-only fields; no hardware event reaches them
   // A bank change moves both the Rn and the pointer addresses on the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         user_flag_a     <= STATUS_RESET[USER_A_BIT];
         user_flag_b     <= STATUS_RESET[USER_B_BIT];
         reg_bank_select <= BANK_RESET;
      end else if (status_write) begin
         user_flag_a     <= write_byte[USER_A_BIT];
         user_flag_b     <= write_byte[USER_B_BIT];
         reg_bank_select <= write_byte[BANK_HI_BIT:BANK_LO_BIT];
      end
   end

   // Overflow; instructions outside the group leave it alone
   // Other arithmetic still reaches the carry pair, so it gets its own priority here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_flag <= STATUS_RESET[OVERFLOW_BIT];
      end else if (ov_group) begin
         overflow_flag <= next_overflow;
      end else if (status_write) begin
         overflow_flag <= write_byte[OVERFLOW_BIT];
      end
   end

   // Parity follows the accumulator register directly, so it never lags it
   assign parity = ^accumulator_i;

   // Status byte as seen by the core and by software
   assign program_status_word_o = {carry_flag, aux_carry_flag, user_flag_a, reg_bank_select,
                                   overflow_flag, user_flag_b, parity};

   // Register operand and pointer placement in internal RAM
   assign bank_addr_o.reg_address     = {reg_bank_select, reg_index_i};
   assign bank_addr_o.pointer_address = {reg_bank_select, POINTER_PAD, pointer_sel_i};

   // Bus answer one cycle after the take; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_take;
      end
   end

   // Read data captured with the take
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= READ_ZERO;
      end else if (bus_take && !wb_we_i && status_hit) begin
         wb_dat_o <= {READ_PAD, program_status_word_o};
      end else if (bus_take) begin
         wb_dat_o <= READ_ZERO;
      end
   end

   // All checks run on the core clock and stay quiet while reset is held
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Carry: addition carry, subtraction borrow, execution unit beats the bus
   carry_add_a: assert property ((alu_req_i.op == alu_add)
                                 |=> carry_flag == $past(sum_wide[BYTE_TOP + 1]))
      else $error("carry wrong after add");

   carry_addc_a: assert property ((alu_req_i.op == alu_addc)
                                  |=> carry_flag == $past(sum_wide[BYTE_TOP + 1]))
      else $error("carry wrong after add with carry");

   carry_top_a: assert property ((alu_req_i.op == alu_addc && alu_req_i.operand_a[BYTE_TOP]
                                  && alu_req_i.operand_b[BYTE_TOP]) |=> carry_flag)
      else $error("carry missed with both top bits set");

   carry_subb_a: assert property ((alu_req_i.op == alu_subb)
                                  |=> carry_flag == $past(diff_wide[BYTE_TOP + 1]))
      else $error("borrow wrong after subtract");

   borrow_less_a: assert property ((alu_req_i.op == alu_subb
                                   && alu_req_i.operand_a < alu_req_i.operand_b) |=> carry_flag)
      else $error("borrow missed on smaller minuend");

   alu_wins_a: assert property ((status_write && is_arith)
                                |=> carry_flag == $past(next_carry))
      else $error("bus write beat the execution unit");

   // Auxiliary carry: nibble carry or borrow, cleared by the rest
   aux_add_a: assert property ((alu_req_i.op inside {alu_add, alu_addc})
                               |=> aux_carry_flag == $past(sum_nibble[NIBBLE_TOP + 1]))
      else $error("aux carry wrong after add");

   nibble_full_a: assert property ((alu_req_i.op == alu_add
                                   && alu_req_i.operand_a[NIBBLE_TOP:0] == 4'hF
                                   && alu_req_i.operand_b[NIBBLE_TOP:0] != 4'h0) |=> aux_carry_flag)
      else $error("nibble carry missed");

   aux_subb_a: assert property ((alu_req_i.op == alu_subb)
                                |=> aux_carry_flag == $past(diff_nibble[NIBBLE_TOP + 1]))
      else $error("aux borrow wrong after subtract");

   aux_clear_a: assert property ((alu_req_i.op inside {alu_mul, alu_div, alu_other_arith})
                                 |=> !aux_carry_flag && !carry_flag)
      else $error("carry pair not cleared");

   // Software-only fields and the bank map
   user_hold_a: assert property (!status_write |=> $stable({user_flag_a, user_flag_b}))
      else $error("user flag changed without a write");

   user_write_a: assert property (status_write |=> {user_flag_a, user_flag_b, reg_bank_select}
                                  == $past({write_byte[USER_A_BIT], write_byte[USER_B_BIT],
                                            write_byte[BANK_HI_BIT:BANK_LO_BIT]}))
      else $error("user fields did not take the write");

   sel_ignore_a: assert property ((bus_take && wb_we_i && !wb_sel_i[0])
                                  |=> $stable({user_flag_a, user_flag_b, reg_bank_select}))
      else $error("write without low lane changed a field");

   bank_hold_a: assert property (!status_write |=> $stable(reg_bank_select))
      else $error("bank select changed without a write");

   bank_map_a: assert property (bank_addr_o.reg_address[4:3] == program_status_word_o[4:3]
                                && bank_addr_o.reg_address[2:0] == reg_index_i)
      else $error("register address not in selected bank");

   // Overflow group
   ov_signed_a: assert property ((alu_req_i.op == alu_add
                                  && alu_req_i.operand_a == 8'h7F && alu_req_i.operand_b == 8'h01)
                                 |=> overflow_flag)
      else $error("signed overflow missed");

   ov_clear_a: assert property ((alu_req_i.op == alu_add
                                 && alu_req_i.operand_a[BYTE_TOP] != alu_req_i.operand_b[BYTE_TOP])
                                |=> !overflow_flag)
      else $error("overflow set by a mixed-sign add");

   sub_same_a: assert property ((alu_req_i.op == alu_subb
                                 && alu_req_i.operand_a[BYTE_TOP] == alu_req_i.operand_b[BYTE_TOP])
                                |=> !overflow_flag)
      else $error("overflow set by a same-sign subtract");

   ov_mul_a: assert property ((alu_req_i.op == alu_mul)
                              |=> overflow_flag == ($past(product) > 16'h00FF))
      else $error("multiply overflow wrong");

   ov_div_a: assert property ((alu_req_i.op == alu_div)
                              |=> overflow_flag == ($past(alu_req_i.operand_b) == 8'h00))
      else $error("divide by zero flag wrong");

   ov_keep_a: assert property ((!ov_group && !status_write) |=> $stable(overflow_flag))
      else $error("overflow changed outside its group");

   // Parity and indirect pointers
   parity_bit_a: assert property (program_status_word_o[0] == ^accumulator_i)
      else $error("parity does not match accumulator");

   pointer_map_a: assert property (bank_addr_o.pointer_address
                                   == {program_status_word_o[4:3], 2'h0, pointer_sel_i})
      else $error("pointer not in selected bank");

   // Software write and bus answer
   sw_write_a: assert property ((status_write && !is_arith)
                                |=> program_status_word_o[7:1] == $past(write_byte[7:1]))
      else $error("software write not applied");

   ov_write_a: assert property ((status_write && !ov_group)
                                |=> overflow_flag == $past(write_byte[OVERFLOW_BIT]))
      else $error("overflow did not take the write");

   read_data_a: assert property ((bus_take && !wb_we_i && status_hit)
                                 |=> wb_dat_o == {READ_PAD, $past(program_status_word_o)})
      else $error("read data is not the status word");

   read_zero_a: assert property ((bus_take && !status_hit) |=> wb_dat_o == READ_ZERO)
      else $error("unmapped access did not return zero");

   dat_hold_a: assert property (!bus_take |=> $stable(wb_dat_o))
      else $error("read data moved without a request");

   bus_ack_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle");

   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("bus ack without a request");

endmodule

// *** test/exec_unit_model.sv ***
`timescale 1ns/100ps
// Execution unit stand-in: one operation a cycle, a fresh accumulator every cycle
module exec_unit_model (
   input  wire logic                      clk_i,
   input  wire logic                      run_i,
   input  wire logic                      use_pick_i,
   input  wire alu_pkg::alu_request_type  pick_i,
   output alu_pkg::alu_request_type       alu_req_o,
   output logic [7:0]                     accumulator_o,
   output logic [2:0]                     reg_index_o,
   output logic                           pointer_sel_o
);
   import alu_pkg::*;

   // Known values from time zero, so the flags never start from unknowns
   initial begin
      alu_req_o = '{op: alu_none, operand_a: 8'h00, operand_b: 8'h00};
      accumulator_o = 8'h00;
      reg_index_o = 3'h0;
      pointer_sel_o = 1'b0;
   end

   // Random traffic reaches every op code; idle cycles issue no arithmetic
   always @(posedge clk_i) begin
      if (use_pick_i) begin
         alu_req_o <= pick_i;
      end else begin
         alu_req_o.op <= run_i ? alu_op_type'($urandom_range(6, 0)) : alu_none;
         alu_req_o.operand_a <= 8'($urandom);
         alu_req_o.operand_b <= 8'($urandom);
      end
      accumulator_o <= 8'($urandom);
      reg_index_o <= 3'($urandom);
      pointer_sel_o <= 1'($urandom);
   end
endmodule

// *** test/tb_program_status_flags.sv ***
`timescale 1ns/100ps
module tb_program_status_flags;
   import alu_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, run = 0, use_pick = 0, ptr;
   logic [7:0] adr = 8'h00, acc;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, rdat;
   logic ack;
   logic [2:0] ridx;
   logic [7:1] exp_f = 7'h00;
   alu_request_type req, pick = '0;
   bank_address_type baddr;
   logic [7:0] status_byte;
   logic [31:0] notes[$];
   int failures = 0, checks = 0;

   initial forever #12.5 clk_i = ~clk_i;

   exec_unit_model i_exec_unit_model (.clk_i(clk_i), .run_i(run), .use_pick_i(use_pick),
      .pick_i(pick), .alu_req_o(req), .accumulator_o(acc), .reg_index_o(ridx),
      .pointer_sel_o(ptr));
   program_status_flags i_program_status_flags (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .alu_req_i(req), .accumulator_i(acc),
      .reg_index_i(ridx), .pointer_sel_i(ptr), .bank_addr_o(baddr),
      .program_status_word_o(status_byte));

   // Flag update from one operation; add/addc/subb/mul/div own overflow
   function automatic logic [7:1] step(logic [7:1] f, alu_request_type r);
      logic [8:0] s;
      logic [4:0] n;
      logic ci;
      step = f;
      ci = (r.op == alu_add) ? 1'b0 : f[7];
      case (r.op)
         alu_add, alu_addc: begin
            s = r.operand_a + r.operand_b + ci;
            n = r.operand_a[3:0] + r.operand_b[3:0] + ci;
            step[2] = (r.operand_a[7] == r.operand_b[7]) && (s[7] != r.operand_a[7]);
         end
         alu_subb: begin
            s = {1'b0, r.operand_a} - {1'b0, r.operand_b} - ci;
            n = {1'b0, r.operand_a[3:0]} - {1'b0, r.operand_b[3:0]} - ci;
            step[2] = (r.operand_a[7] != r.operand_b[7]) && (s[7] != r.operand_a[7]);
         end
         alu_mul: step[2] = ({8'h00, r.operand_a} * {8'h00, r.operand_b}) > 16'd255;
         alu_div: step[2] = (r.operand_b == 8'h00);
         default: ;
      endcase
      if (r.op inside {alu_add, alu_addc, alu_subb}) step[7:6] = {s[8], n[4]};
      else if (r.op != alu_none) step[7:6] = 2'b00;
   endfunction

   // Predictor: notes read results at the taking edge, ALU wins collisions
   always @(posedge clk_i) begin
      logic [7:1] n;
      n = step(exp_f, req);
      if (cyc && ack !== 1'b1 && !we)
         notes.push_back(adr == STATUS_OFFSET ? {24'h0, exp_f, ^acc} : 0);
      if (cyc && ack !== 1'b1 && we && adr == STATUS_OFFSET && sel[0]) begin
         n[5:3] = dat[5:3];
         n[1] = dat[1];
         if (req.op == alu_none) n[7:6] = dat[7:6];
         if (!(req.op inside {alu_add, alu_addc, alu_subb, alu_mul, alu_div})) n[2] = dat[2];
      end
      exp_f = rst_i ? 7'h00 : n;
   end

   // Read results against the oldest note; outputs checked mid-cycle
   always @(posedge clk_i) if (ack === 1'b1 && !we) begin
      checks++;
      if (notes.size() == 0 || rdat !== notes.pop_front()) begin
         failures++;
         $display("BAD %0t read data", $time);
      end
   end
   always @(negedge clk_i) begin
      checks++;
      if (status_byte !== {exp_f, ^acc}) begin
         failures++;
         $display("BAD %0t status word", $time);
      end
      if (baddr !== {exp_f[4:3], ridx, exp_f[4:3], 2'b00, ptr}) begin
         failures++;
         $display("BAD %0t bank address", $time);
      end
   end

   task automatic tally_and_finish();
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      {cyc, we, adr, sel, dat} <= {1'b1, w, a, s, d};
      for (k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      cyc <= 1'b0;
      if (k == 20) begin
         failures++;
         $display("BAD %0t no ack", $time);
         tally_and_finish();
      end
   endtask

   // Boundary operands: signed overflow, carry chains, product 256/255, zero divisor
   alu_request_type picks[9] = '{'{alu_add, 8'h7F, 8'h01}, '{alu_addc, 8'hFF, 8'h01},
      '{alu_subb, 8'h00, 8'h01}, '{alu_subb, 8'h80, 8'h01}, '{alu_mul, 8'h10, 8'h10},
      '{alu_mul, 8'h0F, 8'h11}, '{alu_div, 8'h05, 8'h00}, '{alu_div, 8'h05, 8'h01},
      '{alu_other_arith, 8'h00, 8'h00}};

   initial begin
      void'($urandom(32'hc910));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, STATUS_OFFSET, 4'hF, 0);
      foreach (picks[i]) begin
         @(posedge clk_i);
         {use_pick, pick} <= {1'b1, picks[i]};
         @(posedge clk_i);
         use_pick <= 1'b0;
         wb(0, STATUS_OFFSET, 4'hF, 0);
      end
      wb(1, 8'h04, 4'hF, 32'h0000_00FF);
      wb(0, 8'h04, 4'hF, 0);
      wb(1, STATUS_OFFSET, 4'hE, 32'h0000_00FF);
      run <= 1'b1;
      repeat (60) begin
         wb(1, STATUS_OFFSET, 4'hF, $urandom);
         wb(0, STATUS_OFFSET, 4'hF, 0);
      end
      repeat (200) @(posedge clk_i);
      tally_and_finish();
   end
endmodule
